/* File: verilog/bus_guard_defines.vh */
// How it works
// RQ1: Twenty-bit address writes never split by DMA
// RQ2: Lockout bit set holds off DMA transfers
// RQ3: Cleared channel enable stops channel requests
// RQ4: Word write loads sixteen bits, upper cleared
// RQ5: Flag events during interleaved RMW still captured
// RQ6: Flags already set stay set through RMW
// RQ7: Reading vector register clears pending flag
// RQ8: Busy peripheral may insert wait states
// RQ9: No DMA access to waiting peripheral
// RQ10: Debug halt preserves pending DMA write data
// RQ11: DMA granted only at CPU cycle boundaries
`ifndef BUS_GUARD_DEFINES_VH
`define BUS_GUARD_DEFINES_VH
`define ADDR_W 20
`define WORD_W 16
`define NUM_CHAN 3
`define NUM_FLAGS 8
`define FIFO_DEPTH 32
`define DATA_W 16
`define SRC_RESET 20'h00000
`define DST_RESET 20'h00000
`endif

/* File: verilog/word_fifo.v */
`timescale 1ns/100ps
module word_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Fill side
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  // Drain side
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  reg full_reg;
  wire full;
  wire [AW:0] wr_ptr_next;
  wire [AW:0] rd_ptr_next;
  wire empty;
  wire push;
  wire pop;
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  // Full is kept in a flop so the fill-side ready leaves a register
  assign full = full_reg;
  assign wr_ptr_next = wr_ptr_reg + {{AW{1'b0}}, push};
  assign rd_ptr_next = rd_ptr_reg + {{AW{1'b0}}, pop};
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign push = in_valid & ~full;
  assign pop = out_ready & ~empty;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end
  always @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
      full_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      full_reg <= (wr_ptr_next[AW-1:0] == rd_ptr_next[AW-1:0]) &&
        (wr_ptr_next[AW] != rd_ptr_next[AW]);
    end
  end
endmodule // word_fifo

/* File: verilog/dma_bus_access_guard.v */
`timescale 1ns/100ps
`include "bus_guard_defines.vh"
module dma_bus_access_guard #(
  parameter NCH = `NUM_CHAN,
  parameter NFL = `NUM_FLAGS,
  parameter AW = `ADDR_W,
  parameter DW = `DATA_W
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // CPU register access
  input wire cpu_cycle_start,
  input wire cpu_cycle_end,
  input wire cpu_wr,
  input wire cpu_wide,
  input wire cpu_dst_sel,
  input wire [1:0] cpu_chan,
  input wire [AW-1:0] cpu_wdata,
  // Controls
  input wire rmw_dma_lockout,
  input wire [NCH-1:0] chan_enable_bit,
  input wire [NCH-1:0] chan_trigger,
  // Interrupt flags of a module
  input wire [NFL-1:0] flag_event,
  input wire [NFL-1:0] flag_sw_clear,
  input wire vector_read,
  input wire [2:0] vector_index,
  // Peripheral slave and debug
  input wire periph_wait,
  input wire debug_halt,
  // DMA write data source
  input wire [DW-1:0] dma_wdata,
  input wire dma_wvalid,
  output wire dma_wready,
  // DMA bus side
  output reg dma_grant,
  output reg [1:0] dma_chan,
  output reg [AW-1:0] dma_src,
  output reg [AW-1:0] dma_dst,
  output reg dma_strobe,
  output reg [DW-1:0] dma_bus_data,
  output reg [NFL-1:0] flag_out
);
  // ----------------------------------------
  // Address registers
  // ----------------------------------------
  reg [AW-1:0] src_reg [0:NCH-1];
  reg [AW-1:0] dst_reg [0:NCH-1];
  reg cpu_busy_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [1:0] chan_reg;
  reg [NCH-1:0] pend_reg;
  reg [NFL-1:0] flag_reg;
  wire [AW-1:0] load_val;
  wire cpu_in_cycle;
  wire [DW-1:0] f_data;
  wire f_valid;
  wire f_ready;
  reg any_pend;
  reg [1:0] pick;
  integer flag_i;
  integer arb_i;
  integer pend_i;
  // Sequencer states
  localparam ST_IDLE = 2'h0;
  localparam ST_REQ = 2'h1;
  localparam ST_HOLD = 2'h2;
  // Word writes clear the upper bits so the address stays in low 64K
  assign load_val = cpu_wide ? cpu_wdata : {{(AW-`WORD_W){1'b0}}, cpu_wdata[`WORD_W-1:0]}; // RQ4
  // CPU cycle counts as busy from its start strobe through its end strobe
  assign cpu_in_cycle = cpu_busy_reg | cpu_cycle_start; // RQ11
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : chan_regs
      always @(posedge ref_clk) begin
        if (rst) begin
          src_reg[g] <= `SRC_RESET;
          dst_reg[g] <= `DST_RESET;
        end else if (cpu_wr && cpu_chan == g) begin
          // Whole value loaded in one edge, DMA cannot interleave it
          if (cpu_dst_sel) begin
            dst_reg[g] <= load_val; // RQ1
          end else begin
            src_reg[g] <= load_val; // RQ1
          end
        end
      end
    end
  endgenerate
  always @(posedge ref_clk) begin
    if (rst) begin
      cpu_busy_reg <= 1'b0;
    end else if (cpu_cycle_end) begin
      cpu_busy_reg <= 1'b0;
    end else if (cpu_cycle_start) begin
      cpu_busy_reg <= 1'b1;
    end
  end
  // ----------------------------------------
  // Interrupt flags
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      flag_reg <= {NFL{1'b0}};
    end else begin
      for (flag_i = 0; flag_i < NFL; flag_i = flag_i + 1) begin
        // Set wins over any clear, so DMA interleave cannot drop an event
        if (flag_event[flag_i]) begin
          flag_reg[flag_i] <= 1'b1; // RQ5
        end else if (vector_read && vector_index == flag_i) begin
          flag_reg[flag_i] <= 1'b0; // RQ7
        end else if (flag_sw_clear[flag_i]) begin
          flag_reg[flag_i] <= 1'b0;
        end else begin
          flag_reg[flag_i] <= flag_reg[flag_i]; // RQ6
        end
      end
    end
  end
  // ----------------------------------------
  // Request arbitration
  // ----------------------------------------
  always @* begin
    any_pend = 1'b0;
    pick = 2'h0;
    for (arb_i = NCH - 1; arb_i >= 0; arb_i = arb_i - 1) begin
      if (pend_reg[arb_i]) begin
        any_pend = 1'b1;
        pick = arb_i[1:0];
      end
    end
  end
  always @(posedge ref_clk) begin
    if (rst) begin
      pend_reg <= {NCH{1'b0}};
    end else begin
      for (pend_i = 0; pend_i < NCH; pend_i = pend_i + 1) begin
        if (!chan_enable_bit[pend_i]) begin
          pend_reg[pend_i] <= 1'b0; // RQ3
        end else if (chan_trigger[pend_i]) begin
          pend_reg[pend_i] <= 1'b1;
        end else if (state_reg == ST_HOLD && state_next == ST_IDLE && chan_reg == pend_i) begin
          pend_reg[pend_i] <= 1'b0;
        end
      end
    end
  end
  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  // Pending write data waits in the buffer while halted, never dropped
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // Hold off during lockout or any CPU cycle in flight
        if (any_pend && f_valid && !rmw_dma_lockout && !cpu_in_cycle) begin // RQ2 RQ11
          state_next = ST_REQ;
        end
      end
      ST_REQ: begin
        if (!chan_enable_bit[chan_reg]) begin
          state_next = ST_IDLE; // RQ3
        end else if (!periph_wait && !debug_halt) begin // RQ9 RQ8 RQ10
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end
  assign f_ready = (state_reg == ST_HOLD); // RQ10
  always @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      chan_reg <= 2'h0;
      dma_grant <= 1'b0;
      dma_chan <= 2'h0;
      dma_src <= {AW{1'b0}};
      dma_dst <= {AW{1'b0}};
      dma_strobe <= 1'b0;
      dma_bus_data <= {DW{1'b0}};
      flag_out <= {NFL{1'b0}};
    end else begin
      state_reg <= state_next;
      flag_out <= flag_reg;
      dma_strobe <= 1'b0;
      if (state_reg == ST_IDLE && state_next == ST_REQ) begin
        chan_reg <= pick;
      end
      dma_grant <= (state_next != ST_IDLE);
      if (state_next == ST_HOLD) begin
        // Strobe only once the slave is free of wait states
        dma_strobe <= 1'b1; // RQ9
        dma_chan <= chan_reg;
        dma_src <= src_reg[chan_reg];
        dma_dst <= dst_reg[chan_reg];
        dma_bus_data <= f_data;
      end
    end
  end
  // ----------------------------------------
  // Write data buffer
  // ----------------------------------------
  word_fifo #(
    .WIDTH(DW),
    .DEPTH(`FIFO_DEPTH),
    .AW(5)
  ) data_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(dma_wdata),
    .in_valid(dma_wvalid),
    .in_ready(dma_wready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );
endmodule // dma_bus_access_guard

/* File: verification/periph_slave_model.sv */
`timescale 1ns/100ps
// ----
// Busy slave
// ----
module periph_slave_model #(parameter BUSY = 12) (
  // Clock and reset
  input logic ref_clk,
  input logic rst,
  // Operation start and wait state
  input logic busy_req,
  output logic periph_wait
);
  int cnt;
  always @(posedge ref_clk) begin
    if (rst) cnt <= 0;
    else if (busy_req) cnt <= BUSY;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  // Waits while its operation runs
  assign periph_wait = (cnt != 0);
endmodule // periph_slave_model

/* File: verification/dma_guard_chk.sv */
`timescale 1ns/100ps
// ----
// Bus guard checker
// ----
module dma_guard_chk (
  input logic ref_clk,
  input logic rst,
  input logic cpu_cycle_start, rmw_dma_lockout, vector_read, periph_wait, debug_halt,
  input logic [2:0] chan_enable_bit, vector_index,
  input logic [7:0] flag_event, flag_sw_clear, flag_out,
  input logic dma_grant, dma_strobe,
  input logic [1:0] dma_chan
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [2:0] en_q;
  always_ff @(posedge ref_clk) en_q <= chan_enable_bit;
  property p_shape; dma_strobe |-> dma_grant ##1 !dma_grant && !dma_strobe; endproperty
  a_shape: assert property (p_shape) else $error("strobe shape");
  property p_cpu; $rose(dma_grant) |-> !$past(cpu_cycle_start, 1); endproperty
  a_cpu: assert property (p_cpu) else $error("grant in cpu cycle");
  property p_lock; $rose(dma_grant) |-> !$past(rmw_dma_lockout, 1); endproperty
  a_lock: assert property (p_lock) else $error("grant under lockout");
  property p_en; dma_strobe |-> en_q[dma_chan]; endproperty
  a_en: assert property (p_en) else $error("disabled channel");
  property p_wait; dma_strobe |-> !$past(periph_wait); endproperty
  a_wait: assert property (p_wait) else $error("strobe in wait");
  property p_halt; dma_strobe |-> !$past(debug_halt); endproperty
  a_halt: assert property (p_halt) else $error("strobe in halt");
  property p_set; |flag_event |-> ##2 (flag_out & $past(flag_event, 2)) == $past(flag_event, 2);
  endproperty
  a_set: assert property (p_set) else $error("flag lost");
  property p_keep; |($past(flag_out) & ~flag_out) |-> $past(vector_read, 2) ||
    |$past(flag_sw_clear, 2);
  endproperty
  a_keep: assert property (p_keep) else $error("flag dropped");
  property p_vec; vector_read && !flag_event[vector_index] |-> ##2
    !flag_out[$past(vector_index, 2)]; endproperty
  a_vec: assert property (p_vec) else $error("vector read no clear");
  c_xfer: cover property (dma_strobe);
  c_wait: cover property ($fell(periph_wait) ##[1:5] dma_strobe);
  c_vec: cover property (vector_read);
endmodule // dma_guard_chk
bind dma_bus_access_guard dma_guard_chk i_chk (.*);

/* File: verification/tb.sv */
`timescale 1ns/100ps
// ----
// Scenarios
// ----
module tb;
  logic ref_clk = 0, rst = 1, cpu_cycle_start = 0, cpu_cycle_end = 0, cpu_wr = 0;
  logic cpu_wide = 0, cpu_dst_sel = 0, rmw_dma_lockout = 0, vector_read = 0;
  logic debug_halt = 0, dma_wvalid = 0, busy_req = 0;
  logic periph_wait, dma_wready, dma_grant, dma_strobe;
  logic [1:0] cpu_chan = 0, dma_chan;
  logic [19:0] cpu_wdata = 0, dma_src, dma_dst;
  logic [2:0] chan_enable_bit = 3'h3, chan_trigger = 0, vector_index = 0;
  logic [7:0] flag_event = 0, flag_sw_clear = 0, flag_out;
  logic [15:0] dma_wdata = 0, dma_bus_data;
  logic [19:0] src_e [3], dst_e [3];
  int n_mismatch = 0, compares = 0, k = 0;
  dma_bus_access_guard i_dut (.*);
  periph_slave_model i_slave (.*);
  initial forever #50 ref_clk = ~ref_clk;
  task tick; @(posedge ref_clk); #1; endtask
  task wrap_up;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [19:0] g, input logic [19:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task cpu_write(input [1:0] ch, input dst, input wide, input [19:0] d);
    {cpu_cycle_start, cpu_wr, cpu_chan, cpu_dst_sel, cpu_wide, cpu_wdata} = {2'h3, ch, dst, wide, d};
    tick;
    {cpu_cycle_start, cpu_wr, cpu_cycle_end} = 3'h1;
    tick;
    cpu_cycle_end = 1'h0;
  endtask
  task trig(input int ch);
    chan_trigger[ch] = 1'h1;
    tick;
    chan_trigger = 3'h0;
  endtask
  // Nothing may reach the bus for n cycles
  task quiet(input int n);
    repeat (n) begin tick; chk(dma_strobe, 20'h0); end
  endtask
  // Bounded wait; the buffer hands words out in fill order
  task xfer(input [1:0] ch);
    int n;
    n = 0;
    while (dma_strobe !== 1'h1 && n < 40) begin tick; n++; end
    if (dma_strobe !== 1'h1) begin n_mismatch++; wrap_up; end
    chk(dma_bus_data, 20'h01000 + k);
    chk(dma_grant, 20'h1);
    chk(dma_chan, ch);
    chk(dma_src, src_e[ch]);
    chk(dma_dst, dst_e[ch]);
    k++;
    tick;
    chk(dma_grant, 20'h0);
  endtask
  task sc_addr;
    cpu_write(0, 0, 1, 20'habcde); src_e[0] = 20'habcde;
    cpu_write(0, 1, 0, 20'h51234); dst_e[0] = 20'h01234;
    cpu_write(1, 0, 0, 20'hf5678); src_e[1] = 20'h05678;
    cpu_write(1, 1, 1, 20'h9a0b1); dst_e[1] = 20'h9a0b1;
  endtask
  task sc_fill;
    dma_wvalid = 1'h1;
    for (int i = 0; i < 32; i++) begin
      dma_wdata = 16'h1000 + i;
      chk(dma_wready, 20'h1);
      tick;
    end
    chk(dma_wready, 20'h0);
    dma_wvalid = 1'h0;
  endtask
  // Address write lands while a transfer is held pending
  task sc_lock;
    rmw_dma_lockout = 1'h1;
    trig(0);
    cpu_write(0, 0, 1, 20'h3c3c3); src_e[0] = 20'h3c3c3;
    quiet(6);
    // A CPU cycle in flight still holds off the start once lockout ends
    cpu_cycle_start = 1'h1;
    tick;
    cpu_cycle_start = 1'h0;
    rmw_dma_lockout = 1'h0;
    quiet(4);
    cpu_cycle_end = 1'h1;
    tick;
    cpu_cycle_end = 1'h0;
    xfer(0);
  endtask
  task sc_dis;
    chan_enable_bit = 3'h2;
    trig(0);
    quiet(6);
    chan_enable_bit = 3'h3;
    quiet(6);
  endtask
  task sc_wait;
    busy_req = 1'h1; tick; busy_req = 1'h0;
    trig(1);
    quiet(8);
    xfer(1);
  endtask
  task sc_halt;
    debug_halt = 1'h1;
    trig(0);
    quiet(6);
    chk(dma_grant, 20'h1);
    // Enable drop while waiting aborts the request, data stays buffered
    chan_enable_bit = 3'h2;
    tick;
    chan_enable_bit = 3'h3;
    debug_halt = 1'h0;
    chk(dma_grant, 20'h0);
    quiet(6);
    trig(0);
    xfer(0);
  endtask
  // Flag traffic while a transfer is in flight
  task sc_flags;
    busy_req = 1'h1; tick; busy_req = 1'h0;
    trig(0);
    flag_event = 8'h05; tick;
    flag_event = 8'h02; tick;
    flag_event = 8'h00; tick;
    chk(flag_out, 20'h07);
    vector_read = 1'h1; tick; vector_read = 1'h0; tick;
    chk(flag_out, 20'h06);
    // Clear of one bit while another sets, the older flag untouched
    flag_sw_clear = 8'h02;
    flag_event = 8'h01;
    tick;
    flag_sw_clear = 8'h00;
    flag_event = 8'h00;
    tick;
    chk(flag_out, 20'h05);
    // Event and clear on one bit in one cycle: the event wins
    flag_sw_clear = 8'h05;
    flag_event = 8'h04;
    tick;
    flag_sw_clear = 8'h00;
    flag_event = 8'h00;
    tick;
    chk(flag_out, 20'h04);
    flag_sw_clear = 8'h04; tick; flag_sw_clear = 8'h00; tick;
    chk(flag_out, 20'h00);
    xfer(0);
  endtask
  task sc_drain;
    while (k < 32) begin trig(k[0]); xfer(k[0]); end
    chk(dma_wready, 20'h1);
    trig(0);
    quiet(6);
  endtask
  initial begin
    repeat (4) tick;
    rst = 1'h0;
    sc_addr; sc_fill; sc_lock; sc_dis; sc_wait; sc_halt; sc_flags; sc_drain;
    wrap_up;
  end
endmodule // tb
